// File: hw/imcr_pkg.sv
package imcr_pkg;
  // Register indices (printed offsets are not all multiples of four)
  localparam logic [7:0] IDX_BASE_LOW      = 8'h5B;
  localparam logic [7:0] IDX_BASE_HIGH     = 8'h5C;
  localparam logic [7:0] IDX_PAYLOAD       = 8'h5E;
  localparam logic [7:0] IDX_FAULT         = 8'h5F;
  localparam logic [7:0] IDX_AUX_TRIM      = 8'h68;
  localparam logic [7:0] IDX_RETRIM        = 8'h69;
  localparam logic [7:0] IDX_NVM           = 8'h6A;
  localparam logic [7:0] IDX_SERIAL        = 8'h6B;
  localparam logic [7:0] IDX_PAD           = 8'h6C;
  localparam logic [7:0] IDX_SELFTEST      = 8'h6D;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h80;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'h81;

  // Reset values
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_AUX_TRIM      = 8'h01;
  localparam logic [7:0] RST_PAD           = 8'hFF;

  // Writable field masks; MSK_FAULT marks the defined fault bits
  localparam logic [7:0] MSK_BASE_LOW      = 8'h0F;
  localparam logic [7:0] MSK_AUX_TRIM      = 8'h07;
  localparam logic [7:0] MSK_NVM           = 8'h02;
  localparam logic [7:0] MSK_SERIAL        = 8'h33;
  localparam logic [7:0] MSK_SELFTEST      = 8'h0D;
  localparam logic [7:0] MSK_FAULT         = 8'h16;

  // Field positions
  localparam int BIT_FAULT_SLOW    = 1;
  localparam int BIT_FAULT_FATAL   = 2;
  localparam int BIT_FAULT_FEAT    = 4;
  localparam int BIT_RT_RUNNING    = 2;
  localparam int BIT_RT_PACING     = 3;
  localparam int BIT_SP_PRIMARY    = 0;
  localparam int BIT_SP_STAB       = 1;
  localparam int BIT_SP_STAB_EN    = 4;
  localparam int BIT_SP_AUX_EN     = 5;
  localparam int BIT_ST_EN         = 0;
  localparam int BIT_ST_SIGN       = 2;
  localparam int BIT_ST_AMP        = 3;
  localparam int BIT_NVM_PROG      = 1;

  // Interrupt status bits
  localparam int IRQ_SLOW          = 0;
  localparam int IRQ_FATAL         = 1;
  localparam int IRQ_FEAT          = 2;
  localparam int IRQ_RETRIM_DONE   = 3;
  localparam int IRQ_WIDTH         = 4;

  // Geometry
  localparam int ADDR_W            = 12;
  localparam int LOW_W             = 4;
  localparam int BUS_ADDR_W        = 10;
  localparam int MEM_BYTES         = 8192;
  localparam int MEM_AW            = 13;

  // Bus answer states
  typedef enum logic [2:0] {
    IMCR_IDLE = 3'b001,
    IMCR_RESP = 3'b010,
    IMCR_DONE = 3'b100
  } imcr_bus_state_t;
endpackage

// File: hw/imcr_sticky.sv
`timescale 1ns/1ps
// Sticky flag: set wins over clear
module imcr_sticky (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Control
  input  wire logic set_i,
  input  wire logic clr_i,
  // State
  output logic      flag_q
);
  // Hold until cleared; a coincident set survives
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (set_i) begin
      flag_q <= 1'b1;
    end else if (clr_i) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// File: hw/imcr_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser, change taken when stages two and three agree
module imcr_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  // Pin
  input  wire logic pin_i,
  // Clean level
  output logic      level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Shift chain
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept once stable
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule

// File: hw/imcr_regs.sv
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: high register gives base address bits 11..4
// RULE2: low register gives base address bits 3..0
// RULE3: host advances base by burst bytes/2
// RULE4: single full burst needs no base update
// RULE5: payload port bytes stored as init data
// RULE6: burst bytes land at consecutive locations
// RULE7: fault bit one: processing too slow, halted
// RULE8: fault bit two: fatal error, halted
// RULE9: fault bit four: feature engine disabled
// RULE10: host ignores reserved fault bits
// RULE11: retrim bit two running, clears when done
// RULE12: retrim bit three pacing flag, one complete
// RULE13: primary bit zero: four or three wire
// RULE14: stabilizer bit one, only when enabled
// RULE15: auxiliary enable wins over stabilizer enable
// RULE16: self-test bit zero enables excitation
// RULE17: self-test bit two selects sign
// RULE18: self-test bit three selects amplitude
module imcr_regs (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Internal events (same clock) and pacing pin (synchronised)
  input  wire logic        evt_slow_halt,
  input  wire logic        evt_fatal_halt,
  input  wire logic        evt_feat_disabled,
  input  wire logic        evt_retrim_done,
  input  wire logic        dl_complete_pin,
  // Configuration outputs
  output logic             primary_three_wire_select,
  output logic             stabilizer_three_wire_select,
  output logic             stabilizer_active,
  output logic             aux_active,
  output logic             selftest_enable,
  output logic             selftest_positive,
  output logic             selftest_high_amp,
  output logic             nvm_program_enable,
  output logic [1:0]       aux_pullup_select,
  output logic [7:0]       pad_strength_q,
  output logic             retrim_running,
  // Init image read back port
  input  wire logic [12:0] img_rd_addr,
  output logic [7:0]       img_rd_data,
  // Interrupt
  output logic             irq
);
  logic [7:0]  base_low_q;
  logic [7:0]  base_high_q;
  logic [7:0]  payload_q;
  logic [7:0]  aux_trim_q;
  logic        rt_run_q;
  logic [7:0]  nvm_q;
  logic [7:0]  serial_q;
  logic [7:0]  selftest_q;
  logic [7:0]  irq_mask_q;
  logic [12:0] wptr_q;
  logic        in_burst_q;
  logic [7:0]  image_mem [0:imcr_pkg::MEM_BYTES-1];
  logic [7:0]  rd_byte;
  logic [7:0]  idx;
  logic        wr_take;
  logic        rd_take;
  logic        wr_lane;
  logic [7:0]  wbyte;
  logic        dl_complete;
  logic [imcr_pkg::IRQ_WIDTH-1:0] irq_stat;
  logic [imcr_pkg::IRQ_WIDTH-1:0] irq_set;
  logic [imcr_pkg::IRQ_WIDTH-1:0] irq_clr;
  logic [7:0]  fault_view;
  logic [11:0] base_addr;
  imcr_pkg::imcr_bus_state_t state_q;

  // Address decode and strobes
  assign idx     = avs_address[7:0];
  assign wr_lane = avs_byteenable[0];
  assign wbyte   = avs_writedata[7:0];
  assign wr_take = (state_q == imcr_pkg::IMCR_IDLE) && avs_write && wr_lane
                   && (avs_address[9:8] == 2'b00);
  assign rd_take = (state_q == imcr_pkg::IMCR_IDLE) && avs_read;

  // Full base address
  assign base_addr = {base_high_q, base_low_q[imcr_pkg::LOW_W-1:0]}; // RULE1 RULE2

  // Pacing pin crossing
  imcr_sync u_sync (
    .clk_sys (clk_sys),
    .srst    (srst),
    .pin_i   (dl_complete_pin),
    .level_q (dl_complete)
  );

  // Interrupt event sources
  assign irq_set[imcr_pkg::IRQ_SLOW]        = evt_slow_halt;
  assign irq_set[imcr_pkg::IRQ_FATAL]       = evt_fatal_halt;
  assign irq_set[imcr_pkg::IRQ_FEAT]        = evt_feat_disabled;
  assign irq_set[imcr_pkg::IRQ_RETRIM_DONE] = evt_retrim_done;
  assign irq_clr = (wr_take && idx == imcr_pkg::IDX_IRQ_STATUS)
                   ? wbyte[imcr_pkg::IRQ_WIDTH-1:0] : '0;

  // Sticky status bits, write one to clear
  genvar gi;
  generate
    for (gi = 0; gi < imcr_pkg::IRQ_WIDTH; gi++) begin : g_irq
      imcr_sticky u_flag (
        .clk_sys (clk_sys),
        .srst    (srst),
        .set_i   (irq_set[gi]),
        .clr_i   (irq_clr[gi]),
        .flag_q  (irq_stat[gi])
      );
    end
  endgenerate

  // Fault flags reflect latched halt and feature-disabled status bits
  always_comb begin
    fault_view = imcr_pkg::RST_ZERO;
    fault_view[imcr_pkg::BIT_FAULT_SLOW]  = irq_stat[imcr_pkg::IRQ_SLOW];  // RULE7
    fault_view[imcr_pkg::BIT_FAULT_FATAL] = irq_stat[imcr_pkg::IRQ_FATAL]; // RULE8
    fault_view[imcr_pkg::BIT_FAULT_FEAT]  = irq_stat[imcr_pkg::IRQ_FEAT];  // RULE9
  end

  // Bus answer sequencing: two wait cycles, then ready
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= imcr_pkg::IMCR_IDLE;
    end else begin
      unique case (state_q)
        imcr_pkg::IMCR_IDLE: begin
          if (avs_read || avs_write) begin
            state_q <= imcr_pkg::IMCR_RESP;
          end
        end
        imcr_pkg::IMCR_RESP: begin
          state_q <= imcr_pkg::IMCR_DONE;
        end
        imcr_pkg::IMCR_DONE: begin
          state_q <= imcr_pkg::IMCR_IDLE;
        end
        default: begin
          state_q <= imcr_pkg::IMCR_IDLE;
        end
      endcase
    end
  end

  // Waitrequest low only for the answer cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(state_q == imcr_pkg::IMCR_RESP);
    end
  end

  // Read mux
  always_comb begin
    rd_byte = imcr_pkg::RST_ZERO;
    if (avs_address[9:8] == 2'b00) begin
      unique case (idx)
        imcr_pkg::IDX_BASE_LOW:   rd_byte = base_low_q & imcr_pkg::MSK_BASE_LOW;
        imcr_pkg::IDX_BASE_HIGH:  rd_byte = base_high_q;
        imcr_pkg::IDX_PAYLOAD:    rd_byte = payload_q;
        imcr_pkg::IDX_FAULT:      rd_byte = fault_view;
        imcr_pkg::IDX_AUX_TRIM:   rd_byte = aux_trim_q;
        imcr_pkg::IDX_RETRIM: begin
          rd_byte[imcr_pkg::BIT_RT_RUNNING] = rt_run_q;    // RULE11
          rd_byte[imcr_pkg::BIT_RT_PACING]  = dl_complete; // RULE12
        end
        imcr_pkg::IDX_NVM:        rd_byte = nvm_q;
        imcr_pkg::IDX_SERIAL:     rd_byte = serial_q;
        imcr_pkg::IDX_PAD:        rd_byte = pad_strength_q;
        imcr_pkg::IDX_SELFTEST:   rd_byte = selftest_q;
        imcr_pkg::IDX_IRQ_STATUS: rd_byte = {4'h0, irq_stat};
        imcr_pkg::IDX_IRQ_MASK:   rd_byte = irq_mask_q;
        default:                  rd_byte = imcr_pkg::RST_ZERO;
      endcase
    end
  end

  // Read data captured at request, held through answer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      base_low_q     <= imcr_pkg::RST_ZERO;
      base_high_q    <= imcr_pkg::RST_ZERO;
      aux_trim_q     <= imcr_pkg::RST_AUX_TRIM;
      nvm_q          <= imcr_pkg::RST_ZERO;
      serial_q       <= imcr_pkg::RST_ZERO;
      pad_strength_q <= imcr_pkg::RST_PAD;
      selftest_q     <= imcr_pkg::RST_ZERO;
      irq_mask_q     <= imcr_pkg::RST_ZERO;
    end else if (wr_take) begin
      unique case (idx)
        imcr_pkg::IDX_BASE_LOW:  base_low_q     <= wbyte & imcr_pkg::MSK_BASE_LOW; // RULE2
        imcr_pkg::IDX_BASE_HIGH: base_high_q    <= wbyte; // RULE1
        imcr_pkg::IDX_AUX_TRIM:  aux_trim_q     <= wbyte & imcr_pkg::MSK_AUX_TRIM;
        imcr_pkg::IDX_NVM:       nvm_q          <= wbyte & imcr_pkg::MSK_NVM;
        imcr_pkg::IDX_SERIAL:    serial_q       <= wbyte & imcr_pkg::MSK_SERIAL;
        imcr_pkg::IDX_PAD:       pad_strength_q <= wbyte;
        imcr_pkg::IDX_SELFTEST:  selftest_q     <= wbyte & imcr_pkg::MSK_SELFTEST;
        imcr_pkg::IDX_IRQ_MASK:  irq_mask_q     <= {4'h0, wbyte[imcr_pkg::IRQ_WIDTH-1:0]};
        default: begin
        end
      endcase
    end
  end

  // Retrim running: host sets it, completion clears it and wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rt_run_q <= 1'b0;
    end else if (evt_retrim_done) begin
      rt_run_q <= 1'b0; // RULE11
    end else if (wr_take && idx == imcr_pkg::IDX_RETRIM) begin
      rt_run_q <= wbyte[imcr_pkg::BIT_RT_RUNNING];
    end
  end

  // Payload port and burst write pointer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      payload_q  <= imcr_pkg::RST_ZERO;
      wptr_q     <= '0;
      in_burst_q <= 1'b0;
    end else begin
      if (wr_take && idx == imcr_pkg::IDX_PAYLOAD) begin
        payload_q  <= wbyte; // RULE5
        in_burst_q <= 1'b1;
        if (in_burst_q) begin
          wptr_q <= wptr_q + 13'h0001; // RULE6
        end else begin
          wptr_q <= {base_addr, 1'b0} + 13'h0001; // RULE6 RULE3
        end
      end else if (wr_take) begin
        in_burst_q <= 1'b0; // Other write ends the burst
      end
    end
  end

  // Image store: base counts 16-bit words, so byte index is base*2
  always_ff @(posedge clk_sys) begin
    if (wr_take && idx == imcr_pkg::IDX_PAYLOAD) begin
      image_mem[in_burst_q ? wptr_q : {base_addr, 1'b0}] <= wbyte; // RULE5 RULE4
    end
    img_rd_data <= image_mem[img_rd_addr];
  end

  // Configuration outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      primary_three_wire_select    <= 1'b0;
      stabilizer_three_wire_select <= 1'b0;
      stabilizer_active            <= 1'b0;
      aux_active                   <= 1'b0;
      selftest_enable              <= 1'b0;
      selftest_positive            <= 1'b0;
      selftest_high_amp            <= 1'b0;
      nvm_program_enable           <= 1'b0;
      aux_pullup_select            <= imcr_pkg::RST_AUX_TRIM[1:0];
      retrim_running               <= 1'b0;
      irq                          <= 1'b0;
    end else begin
      primary_three_wire_select <= serial_q[imcr_pkg::BIT_SP_PRIMARY]; // RULE13
      aux_active        <= serial_q[imcr_pkg::BIT_SP_AUX_EN]; // RULE15
      stabilizer_active <= serial_q[imcr_pkg::BIT_SP_STAB_EN]
                           && !serial_q[imcr_pkg::BIT_SP_AUX_EN]; // RULE15
      stabilizer_three_wire_select <= serial_q[imcr_pkg::BIT_SP_STAB]
                                      && serial_q[imcr_pkg::BIT_SP_STAB_EN]
                                      && !serial_q[imcr_pkg::BIT_SP_AUX_EN]; // RULE14
      selftest_enable    <= selftest_q[imcr_pkg::BIT_ST_EN];   // RULE16
      selftest_positive  <= selftest_q[imcr_pkg::BIT_ST_SIGN]; // RULE17
      selftest_high_amp  <= selftest_q[imcr_pkg::BIT_ST_AMP];  // RULE18
      nvm_program_enable <= nvm_q[imcr_pkg::BIT_NVM_PROG];
      aux_pullup_select  <= aux_trim_q[1:0];
      retrim_running     <= rt_run_q;
      irq                <= |(irq_stat & irq_mask_q[imcr_pkg::IRQ_WIDTH-1:0]);
    end
  end
endmodule

// File: sim/imcr_regs_properties.sv
`timescale 1ns/1ps
// Bus timing and configuration checks on the register bank ports
module imcr_regs_properties (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // Avalon-MM slave
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Events and configuration
  input wire logic        evt_retrim_done,
  input wire logic        retrim_running,
  input wire logic        primary_three_wire_select,
  input wire logic        stabilizer_three_wire_select,
  input wire logic        stabilizer_active,
  input wire logic        aux_active,
  input wire logic        selftest_enable,
  input wire logic        selftest_positive,
  input wire logic        selftest_high_amp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  // Request taken, answer low for exactly one cycle
  sequence s_taken; $rose(avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_answer; avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest; endsequence
  // Write answer edge for one register index
  sequence s_wr(logic [9:0] a);
    !avs_waitrequest && avs_write && avs_byteenable[0] && avs_address == a;
  endsequence

  property p_answer; s_taken |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("answer timing wrong");
  property p_idle; !(avs_read || avs_write) |-> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("waitrequest low while idle");
  property p_upper; !avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h000000; endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  property p_unmapped;
    !avs_waitrequest && avs_read && avs_address[9:8] != 2'b00 |-> avs_readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_selftest;
    s_wr(10'h06D) |-> selftest_enable == avs_writedata[0] && selftest_positive == avs_writedata[2]
      && selftest_high_amp == avs_writedata[3];
  endproperty
  a_selftest: assert property (p_selftest) else $error("self-test fields wrong");
  property p_serial;
    s_wr(10'h06B) |-> primary_three_wire_select == avs_writedata[0]
      && aux_active == avs_writedata[5];
  endproperty
  a_serial: assert property (p_serial) else $error("wiring fields wrong");
  property p_stab_gate;
    stabilizer_three_wire_select |-> stabilizer_active && !aux_active;
  endproperty
  a_stab_gate: assert property (p_stab_gate) else $error("stabilizer mode ungated");
  property p_aux_wins; aux_active |-> !stabilizer_active; endproperty
  a_aux_wins: assert property (p_aux_wins) else $error("aux lost priority");
  property p_retrim; evt_retrim_done |-> ##2 !retrim_running; endproperty
  a_retrim: assert property (p_retrim) else $error("retrim still running");
endmodule

bind imcr_regs imcr_regs_properties u_props (
  .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .evt_retrim_done(evt_retrim_done), .retrim_running(retrim_running),
  .primary_three_wire_select(primary_three_wire_select),
  .stabilizer_three_wire_select(stabilizer_three_wire_select),
  .stabilizer_active(stabilizer_active), .aux_active(aux_active),
  .selftest_enable(selftest_enable), .selftest_positive(selftest_positive),
  .selftest_high_amp(selftest_high_amp)
);

// File: sim/imcr_host.sv
`timescale 1ns/1ps
// Host model: Avalon-MM master, one access at a time
module imcr_host (
  // Clock
  input  wire logic        clk_sys,
  // Avalon-MM master
  output logic [9:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // Idle bus at time zero
  initial begin
    avs_address    = 10'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'hF;
  end

  // Hold the request until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Image burst: set base, stream bytes, advance base by half the byte count
  task automatic burst(inout logic [11:0] base, input logic [7:0] b[$]);
    logic [7:0] q;
    xfer(1'b1, 10'h05C, base[11:4], 4'hF, q);
    xfer(1'b1, 10'h05B, {4'h0, base[3:0]}, 4'hF, q);
    foreach (b[i]) xfer(1'b1, 10'h05E, b[i], 4'hF, q);
    base = base + 12'(b.size() / 2);
  endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
// Bench: host model drives the bus, integer model predicts each result
module tb_top;
  // Clock, reset and bus
  logic        clk_sys = 1'b0;
  logic        srst    = 1'b1;
  logic [9:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  // Events, pin, image port, outputs
  logic [3:0]  ev      = 4'h0;
  logic        dl_pin  = 1'b0;
  logic [12:0] img_rd_addr = 13'h0000;
  logic [7:0]  img_rd_data, q, pad;
  logic        p3w, s3w, s_act, a_act, st_en, st_pos, st_amp, nvm_en, rt_run, irq;
  logic [1:0]  pup;
  logic [11:0] base;
  logic [7:0]  bq [$];
  // Reference model
  int          error_cnt = 0;
  int          checked   = 0;
  int          cycles    = 0;
  int          seed      = 32'ha3bc;
  int          st        = 0;
  int          mdl [int];
  int          img [int];
  int          regs [11] = '{'h5B, 'h5C, 'h5F, 'h68, 'h69, 'h6A, 'h6B, 'h6C, 'h6D, 'h80, 'h81};

  always #12.5 clk_sys = ~clk_sys;

  imcr_host host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  imcr_regs DUT (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .evt_slow_halt(ev[0]), .evt_fatal_halt(ev[1]),
    .evt_feat_disabled(ev[2]), .evt_retrim_done(ev[3]), .dl_complete_pin(dl_pin),
    .primary_three_wire_select(p3w), .stabilizer_three_wire_select(s3w),
    .stabilizer_active(s_act), .aux_active(a_act), .selftest_enable(st_en),
    .selftest_positive(st_pos), .selftest_high_amp(st_amp), .nvm_program_enable(nvm_en),
    .aux_pullup_select(pup), .pad_strength_q(pad), .retrim_running(rt_run),
    .img_rd_addr(img_rd_addr), .img_rd_data(img_rd_data), .irq(irq));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // Writable bits of each register
  function automatic int wmask(input int a);
    case (a)
      'h5B, 'h81: return 8'h0F;
      'h5C, 'h6C: return 8'hFF;
      'h68: return 8'h07;
      'h69: return 8'h04;
      'h6A: return 8'h02;
      'h6B: return 8'h33;
      'h6D: return 8'h0D;
      default: return 0;
    endcase
  endfunction

  // Expected read value; fault flags mirror status bits
  function automatic int exp_rd(input int a);
    if (a == 'h5F) return ((st & 1) << 1) | ((st & 2) << 1) | ((st & 4) << 2);
    if (a == 'h80) return st;
    return mdl.exists(a) ? mdl[a] : 0;
  endfunction

  task automatic wr(input int a, input logic [7:0] d);
    host.xfer(1'b1, 10'(a), d, 4'hF, q);
    if (a == 'h80) st = st & ~int'(d);
    else if (wmask(a) != 0) mdl[a] = (mdl[a] & ~wmask(a)) | (d & wmask(a));
  endtask

  task automatic rd(input int a);
    host.xfer(1'b0, 10'(a), 8'h00, 4'hF, q);
    chk((a == 'h5F) ? (q & 8'h16) : q, exp_rd(a));
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    foreach (regs[i]) mdl[regs[i]] = 0;
    mdl['h68] = 1;
    mdl['h6C] = 'hFF;
    // Reset values, then random fill with refused accesses
    foreach (regs[i]) rd(regs[i]);
    chk(pup, 2'b01);
    repeat (2) foreach (regs[i]) wr(regs[i], 8'($random(seed)));
    host.xfer(1'b1, 10'h06C, 8'h00, 4'hE, q);
    wr('h15B, 8'hA5);
    foreach (regs[i]) rd(regs[i]);
    rd('h15B);
    chk(pad, mdl['h6C]);
    chk(pup, mdl['h68] & 3);
    // Wiring, priority and self-test fields, every combination
    for (int i = 0; i < 16; i++) begin
      wr('h6B, {2'b00, i[3:2], 2'b00, i[1:0]});
      wr('h6D, 8'(i));
      wr('h6A, 8'(i));
      chk(p3w, i[0]);
      chk(s3w, i[1] & i[2] & !i[3]);
      chk({a_act, s_act}, {i[3], i[2] & !i[3]});
      chk({st_amp, st_pos, st_en}, {i[3], i[2], i[0]});
      chk(nvm_en, i[1]);
    end
    // Two image bursts, then read every byte back
    base = 12'($unsigned($random(seed)) % 4000);
    for (int k = 0; k < 2; k++) begin
      bq.delete();
      repeat (6) bq.push_back(8'($random(seed)));
      foreach (bq[j]) img[base * 2 + j] = bq[j];
      host.burst(base, bq);
    end
    mdl['h5E] = bq[$];
    rd('h5E);
    foreach (img[k]) begin
      img_rd_addr <= 13'(k);
      repeat (2) @(posedge clk_sys);
      chk(img_rd_data, img[k]);
    end
    // Each event: sticky flag, masked, level interrupt, clear by one
    wr('h69, 8'h04);
    for (int e = 0; e < 4; e++) begin
      wr('h81, 8'h00);
      @(posedge clk_sys) ev <= 4'(1 << e);
      @(posedge clk_sys) ev <= 4'h0;
      st = st | (1 << e);
      if (e == 3) mdl['h69] = mdl['h69] & ~4;
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b0);
      chk(rt_run, e < 3);
      rd('h5F);
      rd('h69);
      wr('h81, 8'(1 << e));
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b1);
      wr('h80, 8'(1 << e));
      repeat (3) @(posedge clk_sys);
      chk(irq, 1'b0);
      rd('h5F);
    end
    // Download pacing flag follows the pin
    dl_pin <= 1'b1;
    repeat (8) @(posedge clk_sys);
    mdl['h69] = mdl['h69] | 8;
    rd('h69);
    end_of_test();
  end
endmodule
